// ===== src/plr_router.sv
// Strap-configured router from the pixel port to eight LVDS lanes
//
// The address map and the APB register port were chosen for this implementation.
module plr_router (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pix_clk,
  input wire logic [23:0] pixel_input_bus,
  input wire logic pix_hsync,
  input wire logic pix_vsync,
  input wire logic pix_de,
  input wire logic [1:0] pixel_port_mode_strap,
  input wire logic color_map_strap,
  input wire logic sample_polarity_strap,
  input wire logic [2:0] slave_addr_strap,
  output logic [6:0] slave_addr,
  output logic [55:0] lvds_lane_pos,
  output logic [55:0] lvds_lane_neg,
  output logic [7:0] lane_enable,
  output logic second_lvds_clock_en
);

  // ********************************************************
  // Strap capture (pclk domain)
  // ********************************************************
  logic [6:0] strap_s1; // First synchroniser stage
  logic [6:0] strap_s2; // Second synchroniser stage
  logic [4:0] settle_cnt; // Cycles since reset release
  logic cfg_done; // Straps latched, config stable
  plr_pkg::plr_mode_t cfg_mode; // Decoded pixel port mode
  logic cfg_noncon; // Non-conventional colour map
  logic cfg_pol; // Primary edge is rising when set
  logic [2:0] cfg_addr; // Latched address straps

  // Straps are pins, so two flops before any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1 <= 7'h00;
      strap_s2 <= 7'h00;
    end else begin
      strap_s1 <= {pixel_port_mode_strap, color_map_strap,
                   sample_polarity_strap, slave_addr_strap};
      strap_s2 <= strap_s1;
    end
  end

  // Latch once after settling; straps are static levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= 5'h00;
      cfg_done <= 1'h0;
      cfg_mode <= plr_pkg::PLR_SS;
      cfg_noncon <= 1'h0;
      cfg_pol <= 1'h0;
      cfg_addr <= 3'h0;
      slave_addr <= 7'h00;
    end else if (!cfg_done) begin
      settle_cnt <= settle_cnt + 5'h01;
      if (settle_cnt == plr_pkg::PLR_SETTLE_LAST) begin
        cfg_done <= 1'h1;
        case (strap_s2[plr_pkg::PLR_ST_MODE_LSB +: 2])
          plr_pkg::PLR_STRAP_MID: cfg_mode <= plr_pkg::PLR_SD;
          plr_pkg::PLR_STRAP_VCC: cfg_mode <= plr_pkg::PLR_DD;
          default: cfg_mode <= plr_pkg::PLR_SS;
        endcase
        cfg_noncon <= strap_s2[plr_pkg::PLR_ST_COLOR_BIT];
        cfg_pol <= strap_s2[plr_pkg::PLR_ST_POL_BIT];
        cfg_addr <= strap_s2[plr_pkg::PLR_ST_ADDR_LSB +: 3];
        // Low address bits come straight from the straps
        slave_addr <= {plr_pkg::PLR_SADDR_HIGH,
                       strap_s2[plr_pkg::PLR_ST_ADDR_LSB +: 3]};
      end
    end
  end

  // ********************************************************
  // APB slave (zero wait states)
  // ********************************************************
  logic ctrl_en; // Lanes may drive pixel data
  logic apb_setup; // Setup phase of a transfer
  logic apb_hit; // Address is one of ours
  logic [31:0] next_prdata; // Read data for this address

  assign apb_setup = psel & ~penable;
  assign apb_hit = (paddr == plr_pkg::PLR_CTRL_OFS) ||
                   (paddr == plr_pkg::PLR_STATUS_OFS) ||
                   (paddr == plr_pkg::PLR_SADDR_OFS);

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      plr_pkg::PLR_CTRL_OFS: next_prdata[0] = ctrl_en;
      plr_pkg::PLR_STATUS_OFS: begin
        next_prdata[plr_pkg::PLR_ST_MODE_LSB +: 2] = cfg_mode;
        next_prdata[plr_pkg::PLR_ST_COLOR_BIT] = cfg_noncon;
        next_prdata[plr_pkg::PLR_ST_POL_BIT] = cfg_pol;
        next_prdata[plr_pkg::PLR_ST_ADDR_LSB +: 3] = cfg_addr;
        next_prdata[plr_pkg::PLR_ST_DONE_BIT] = cfg_done;
      end
      plr_pkg::PLR_SADDR_OFS: next_prdata[6:0] = slave_addr;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Answer in the first access cycle; error on unmapped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'h0;
      pslverr <= 1'h0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~apb_hit;
      prdata <= (apb_setup & ~pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  // Write lands on the edge that sees pready high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en <= plr_pkg::PLR_CTRL_EN_RESET;
    end else if (psel && penable && pready && pwrite &&
                 paddr == plr_pkg::PLR_CTRL_OFS) begin
      ctrl_en <= pwdata[plr_pkg::PLR_CTRL_EN_BIT];
    end
  end

  // ********************************************************
  // Pixel clock domain: reset and level crossings
  // ********************************************************
  logic [1:0] prst_sync; // Reset release synchroniser
  logic pix_rst_n; // Pixel domain reset, low active
  logic done_s1; // cfg_done, first stage
  logic cfg_ok; // cfg_done seen in pixel domain
  logic en_s1; // ctrl_en, first stage
  logic en_ok; // ctrl_en seen in pixel domain
  logic out_on; // Lanes carry data this cycle

  // Asserts at once, releases on the pixel clock
  always_ff @(posedge pix_clk or negedge presetn) begin
    if (!presetn) begin
      prst_sync <= 2'h0;
    end else begin
      prst_sync <= {prst_sync[0], 1'h1};
    end
  end
  assign pix_rst_n = prst_sync[1];

  // cfg_* are frozen on the edge that raises cfg_done, so they are
  // safe to read once cfg_ok is high
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      done_s1 <= 1'h0;
      cfg_ok <= 1'h0;
      en_s1 <= 1'h0;
      en_ok <= 1'h0;
    end else begin
      done_s1 <= cfg_done;
      cfg_ok <= done_s1;
      en_s1 <= ctrl_en;
      en_ok <= en_s1;
    end
  end
  assign out_on = cfg_ok & en_ok;

  // ********************************************************
  // Double-edge capture of the 12-bit halves
  // ********************************************************
  logic [26:0] pos_cap; // {vs, hs, de, bus} at rising edge
  logic [26:0] neg_cap; // {vs, hs, de, bus} at falling edge
  logic [23:0] asm_a; // Pixel from bits 0-11
  logic [23:0] asm_b; // Pixel from bits 12-23
  logic [2:0] asm_ctl; // {vs, hs, de} of the primary edge

  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      pos_cap <= 27'h0;
    end else begin
      pos_cap <= {pix_vsync, pix_hsync, pix_de, pixel_input_bus};
    end
  end

  always_ff @(negedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      neg_cap <= 27'h0;
    end else begin
      neg_cap <= {pix_vsync, pix_hsync, pix_de, pixel_input_bus};
    end
  end

  // Primary edge gives the low half, the next edge the high
  always_comb begin
    if (cfg_pol) begin
      // Rising primary, falling half follows it
      asm_a = {neg_cap[11:0], pos_cap[11:0]};
      asm_b = {neg_cap[23:12], pos_cap[23:12]};
      asm_ctl = pos_cap[26:24];
    end else begin
      // Falling primary, completed by this rising edge
      asm_a = {pixel_input_bus[11:0], neg_cap[11:0]};
      asm_b = {pixel_input_bus[23:12], neg_cap[23:12]};
      asm_ctl = neg_cap[26:24];
    end
  end

  // ********************************************************
  // Pixel routing and pairing
  // ********************************************************
  logic [23:0] pix_a; // Pixel for lanes 0-3
  logic [23:0] pix_b; // Pixel for lanes 4-7
  logic [2:0] pix_ctl; // Sync bits for both groups
  logic [23:0] first_hold; // Earlier pixel of a pair
  logic phase; // Set while waiting for the later pixel
  logic pair_go; // Later pixel arrives this cycle

  assign pair_go = (cfg_mode == plr_pkg::PLR_SD) & asm_ctl[0] & phase;

  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      pix_a <= 24'h0;
      pix_b <= 24'h0;
      pix_ctl <= 3'h0;
      first_hold <= 24'h0;
      phase <= 1'h0;
    end else begin
      case (cfg_mode)
        plr_pkg::PLR_SD: begin
          if (!asm_ctl[0]) begin
            // Blanking: restart pairing, pass syncs through
            phase <= 1'h0;
            pix_a <= asm_a;
            pix_b <= asm_a;
            pix_ctl <= asm_ctl;
          end else if (!phase) begin
            // Hold the earlier pixel until its partner
            first_hold <= asm_a;
            phase <= 1'h1;
          end else begin
            pix_a <= first_hold;
            pix_b <= asm_a;
            pix_ctl <= asm_ctl;
            phase <= 1'h0;
          end
        end
        plr_pkg::PLR_DD: begin
          pix_a <= asm_a;
          pix_b <= asm_b;
          pix_ctl <= asm_ctl;
          phase <= 1'h0;
        end
        default: begin
          pix_a <= asm_a;
          pix_b <= 24'h0;
          pix_ctl <= asm_ctl;
          phase <= 1'h0;
        end
      endcase
    end
  end

  // ********************************************************
  // Lane mapping and output registers
  // ********************************************************
  logic [23:0] grp_pix [2]; // Pixel per lane group
  logic [55:0] map_lanes; // Mapped lanes of both groups
  logic [55:0] next_lanes; // Gated lane words

  assign grp_pix[0] = pix_a;
  assign grp_pix[1] = pix_b;

  for (genvar g = 0; g < 2; g++) begin : g_grp
    plr_lane_map i_plr_lane_map (
      .pixel(grp_pix[g]),
      .hsync(pix_ctl[1]),
      .vsync(pix_ctl[2]),
      .de(pix_ctl[0]),
      .noncon(cfg_noncon),
      .lanes(map_lanes[g*plr_pkg::PLR_GRP_W +: plr_pkg::PLR_GRP_W])
    );
  end

  // Upper group stays quiet in single mode
  always_comb begin
    next_lanes = 56'h0;
    if (out_on) begin
      next_lanes[27:0] = map_lanes[27:0];
      if (cfg_mode != plr_pkg::PLR_SS) begin
        next_lanes[55:28] = map_lanes[55:28];
      end
    end
  end

  // Complement kept registered so both legs switch together
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      lvds_lane_pos <= 56'h0;
      lvds_lane_neg <= 56'h0;
      lane_enable <= 8'h00;
      second_lvds_clock_en <= 1'h0;
    end else begin
      lvds_lane_pos <= next_lanes;
      lvds_lane_neg <= ~next_lanes;
      if (!cfg_ok) begin
        lane_enable <= 8'h00;
        second_lvds_clock_en <= 1'h0;
      end else if (cfg_mode == plr_pkg::PLR_SS) begin
        lane_enable <= plr_pkg::PLR_LANES_LOW;
        second_lvds_clock_en <= 1'h0;
      end else begin
        lane_enable <= plr_pkg::PLR_LANES_ALL;
        second_lvds_clock_en <= 1'h1;
      end
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  property p_addr_strap;
    @(posedge pclk) disable iff (!presetn)
    $rose(cfg_done) |-> slave_addr[2:0] == $past(strap_s2[2:0]);
  endproperty
  a_addr_strap: assert property (p_addr_strap)
    else $error("slave address low bits differ from straps");

  property p_rise_edge;
    @(posedge pix_clk) disable iff (!pix_rst_n)
    cfg_ok && cfg_pol && cfg_mode == plr_pkg::PLR_DD |->
      ##2 pix_a[11:0] == $past(pixel_input_bus[11:0], 2);
  endproperty
  a_rise_edge: assert property (p_rise_edge)
    else $error("rising primary edge half not taken");

  property p_fall_edge;
    @(posedge pix_clk) disable iff (!pix_rst_n)
    cfg_ok && !cfg_pol && cfg_mode != plr_pkg::PLR_SD |=>
      pix_a[23:12] == $past(pixel_input_bus[11:0]);
  endproperty
  a_fall_edge: assert property (p_fall_edge)
    else $error("falling primary pixel not completed on rise");

  property p_dual_second;
    @(posedge pix_clk) disable iff (!pix_rst_n)
    cfg_ok && cfg_pol && cfg_mode == plr_pkg::PLR_DD |->
      ##2 pix_b[11:0] == $past(pixel_input_bus[23:12], 2);
  endproperty
  a_dual_second: assert property (p_dual_second)
    else $error("second pixel not from upper input bits");

  property p_pair_second;
    @(posedge pix_clk) disable iff (!pix_rst_n)
    cfg_ok && pair_go |=>
      (cfg_pol ? (pix_b[11:0] == $past(pixel_input_bus[11:0], 2))
               : (pix_b[23:12] == $past(pixel_input_bus[11:0])));
  endproperty
  a_pair_second: assert property (p_pair_second)
    else $error("later pixel of pair not on second group");

  property p_pair_order;
    @(posedge pix_clk) disable iff (!pix_rst_n)
    pair_go |=> pix_a == $past(asm_a, 2) && !phase;
  endproperty
  a_pair_order: assert property (p_pair_order)
    else $error("earlier pixel of pair not on first group");

  property p_single_lanes;
    @(posedge pix_clk) disable iff (!pix_rst_n)
    cfg_ok && cfg_mode == plr_pkg::PLR_SS |=>
      lvds_lane_pos[55:28] == 28'h0 && lane_enable == 8'h0F &&
      !second_lvds_clock_en;
  endproperty
  a_single_lanes: assert property (p_single_lanes)
    else $error("upper lanes active in single mode");

  property p_color_conv;
    @(posedge pix_clk) disable iff (!pix_rst_n)
    out_on && !cfg_noncon |=>
      lvds_lane_pos[6:0] == {$past(pix_a[8]), $past(pix_a[21:16])};
  endproperty
  a_color_conv: assert property (p_color_conv)
    else $error("conventional map wrong on lane 0");

  property p_color_noncon;
    @(posedge pix_clk) disable iff (!pix_rst_n)
    out_on && cfg_noncon |=>
      lvds_lane_pos[27:21] == {1'h0, $past(pix_a[1:0]),
                               $past(pix_a[9:8]), $past(pix_a[17:16])};
  endproperty
  a_color_noncon: assert property (p_color_noncon)
    else $error("non-conventional map wrong on lane 3");

  // Main scenarios
  c_single: cover property (@(posedge pix_clk)
    out_on && cfg_mode == plr_pkg::PLR_SS && pix_ctl[0]);
  c_pair: cover property (@(posedge pix_clk) out_on && pair_go);
  c_dual: cover property (@(posedge pix_clk)
    out_on && cfg_mode == plr_pkg::PLR_DD && pix_ctl[0]);

endmodule

// ===== include/plr_pkg.sv
// Constants, types and register map for the pixel-to-lane router
package plr_pkg;

  // ********************************************************
  // Register map (byte addresses on the APB)
  // ********************************************************
  localparam logic [7:0] PLR_CTRL_OFS = 8'h00;
  localparam logic [7:0] PLR_STATUS_OFS = 8'h04;
  localparam logic [7:0] PLR_SADDR_OFS = 8'h08;

  // Control register: bit 0 lets the lanes drive pixel data
  localparam int PLR_CTRL_EN_BIT = 0;
  localparam logic PLR_CTRL_EN_RESET = 1'h1;

  // Strap vector and status layout
  localparam int PLR_ST_ADDR_LSB = 0;
  localparam int PLR_ST_POL_BIT = 3;
  localparam int PLR_ST_COLOR_BIT = 4;
  localparam int PLR_ST_MODE_LSB = 5;
  localparam int PLR_ST_DONE_BIT = 7;
  localparam int PLR_STRAP_W = 7;

  // Upper bits of the serial slave address; plain default
  localparam logic [3:0] PLR_SADDR_HIGH = 4'h5;

  // ********************************************************
  // Strap settling time after reset release
  // ********************************************************
  localparam int PLR_PCLK_PERIOD_NS = 5;
  localparam int PLR_SETTLE_NS = 100;
  localparam int PLR_SETTLE_CYC =
    (PLR_SETTLE_NS + PLR_PCLK_PERIOD_NS - 1) / PLR_PCLK_PERIOD_NS;
  localparam logic [4:0] PLR_SETTLE_LAST = 5'(PLR_SETTLE_CYC - 1);

  // ********************************************************
  // Lane geometry and pixel port modes
  // ********************************************************
  localparam int PLR_LANE_W = 7;
  localparam int PLR_GRP_W = 4 * PLR_LANE_W;
  localparam logic [7:0] PLR_LANES_LOW = 8'h0F;
  localparam logic [7:0] PLR_LANES_ALL = 8'hFF;

  // Raw tri-level mode strap codes
  localparam logic [1:0] PLR_STRAP_MID = 2'h1;
  localparam logic [1:0] PLR_STRAP_VCC = 2'h2;

  typedef enum logic [1:0] {
    PLR_SS = 2'b00,
    PLR_SD = 2'b01,
    PLR_DD = 2'b10
  } plr_mode_t;

endpackage

// ===== src/plr_lane_map.sv
// One pixel mapped onto a group of four seven-bit lanes
module plr_lane_map (
  input wire logic [23:0] pixel,
  input wire logic hsync,
  input wire logic vsync,
  input wire logic de,
  input wire logic noncon,
  output logic [27:0] lanes
);

  // Colour components: red high, green middle, blue low byte
  logic [7:0] r;
  logic [7:0] g;
  logic [7:0] b;

  assign r = pixel[23:16];
  assign g = pixel[15:8];
  assign b = pixel[7:0];

  // ********************************************************
  // Colour mapping
  // ********************************************************
  // Lane 2 carries the sync and enable bits in both maps
  always_comb begin
    if (noncon) begin
      // Two LSBs of each colour ride on lane 3
      lanes = {1'h0, b[1:0], g[1:0], r[1:0],
               hsync ? {de, vsync, 1'h1, b[7:4]}
                     : {de, vsync, 1'h0, b[7:4]},
               b[3:2], g[7:3],
               g[2], r[7:2]};
    end else begin
      // MSBs ride on lane 3, so 18-bit panels drop it
      lanes = {1'h0, b[7:6], g[7:6], r[7:6],
               de, vsync, hsync, b[5:2],
               b[1:0], g[5:1],
               g[0], r[5:0]};
    end
  end

endmodule

// ===== dv/plr_rx_model.sv
// Receiver model: unpacks the eight lanes back into pixels
module plr_rx_model #(
  parameter bit SIX_BIT = 1'b0  // Set for a 6-bit panel
) (
  input wire logic pix_clk,
  input wire logic presetn,
  input wire logic noncon,
  input wire logic [55:0] lane_pos,
  input wire logic [55:0] lane_neg,
  input wire logic [7:0] lane_en,
  output logic [26:0] grp_a,
  output logic [26:0] grp_b,
  output logic pair_bad
);
  timeunit 1ns;
  timeprecision 1ps;

  // ******
  // Lane unpacking
  // ******
  // Gives {de, vs, hs, red, green, blue} of one group of four lanes
  function automatic logic [26:0] plr_unpack(input logic [27:0] g,
                                             input logic nc);
    logic [6:0] l0, l1, l2, l3;
    logic [7:0] r, gr, b;
    l0 = g[6:0];
    l1 = g[13:7];
    l2 = g[20:14];
    // A 6-bit panel leaves the fourth lane unconnected
    l3 = SIX_BIT ? 7'h00 : g[27:21];
    if (nc) begin
      // Lane 2 carries the blue high nibble in this map
      r = {l0[5:0], l3[1:0]};
      gr = {l1[4:0], l0[6], l3[3:2]};
      b = {l2[3:0], l1[6:5], l3[5:4]};
    end else begin
      r = {l3[1:0], l0[5:0]};
      gr = {l3[3:2], l1[4:0], l0[6]};
      b = {l3[5:4], l2[3:0], l1[6:5]};
    end
    return {l2[6:4], r, gr, b};
  endfunction

  assign grp_a = plr_unpack(lane_pos[27:0], noncon);
  assign grp_b = plr_unpack(lane_pos[55:28], noncon);

  // Sticky: an enabled lane whose two wires are not complementary
  always_ff @(posedge pix_clk or negedge presetn) begin
    if (!presetn) begin
      pair_bad <= 1'b0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (lane_en[i] && (lane_neg[7*i+:7] !== ~lane_pos[7*i+:7])) begin
          pair_bad <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== dv/tb_plr_router.sv
// Self-checking bench for the strap-configured pixel-to-lane router
module tb_plr_router;
  timeunit 1ns;
  timeprecision 1ps;

  // ******
  // Signals
  // ******
  logic pclk = 1'b0;
  logic pix_clk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [23:0] pix_bus = 24'h000000;
  logic pix_de = 1'b0;
  logic pix_hs = 1'b0;
  logic pix_vs = 1'b0;
  logic hs_r = 1'b0;  // Sync levels sent with active video
  logic vs_r = 1'b0;
  logic [1:0] mode = 2'h0;  // Strap levels
  logic color = 1'b0;
  logic pol = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [6:0] slave_addr;
  logic [55:0] lane_pos;
  logic [55:0] lane_neg;
  logic [7:0] lane_en;
  logic second_lvds_clock_out_en;
  logic [26:0] grp_a;
  logic [26:0] grp_b;
  logic pair_bad;
  wire pe = pix_clk ~^ pol;  // Rises on the primary sampling edge
  logic [23:0] px0 = 24'hC396AA;  // Earlier / first port pixel
  logic [23:0] px1 = 24'h69E155;  // Later / second port pixel
  logic [23:0] cur;
  logic de_r = 1'b0;
  logic sd = 1'b0;  // Alternate pixels on the one port
  logic tog = 1'b0;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;

  // Offset keeps link edges clear of pclk edges
  always #2.5 pclk = ~pclk;
  initial begin
    #6.2;
    forever #24 pix_clk = ~pix_clk;
  end

  plr_router i_plr_router (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_clk(pix_clk), .pixel_input_bus(pix_bus), .pix_hsync(pix_hs),
    .pix_vsync(pix_vs), .pix_de(pix_de), .pixel_port_mode_strap(mode),
    .color_map_strap(color), .sample_polarity_strap(pol),
    .slave_addr_strap(addr), .slave_addr(slave_addr),
    .lvds_lane_pos(lane_pos), .lvds_lane_neg(lane_neg),
    .lane_enable(lane_en), .second_lvds_clock_en(second_lvds_clock_out_en)
  );

  plr_rx_model i_plr_rx_model (
    .pix_clk(pix_clk), .presetn(presetn), .noncon(color),
    .lane_pos(lane_pos), .lane_neg(lane_neg), .lane_en(lane_en),
    .grp_a(grp_a), .grp_b(grp_b), .pair_bad(pair_bad)
  );

  // Pixel source: each half is changed on the edge before it is taken
  always begin
    @(negedge pe);
    cur = (sd && tog) ? px1 : px0;
    tog = sd & de_r & ~tog;
    pix_bus <= {px1[11:0], cur[11:0]};
    pix_de <= de_r;
    pix_hs <= hs_r;
    pix_vs <= vs_r;
    @(posedge pe);
    pix_bus <= {px1[23:12], cur[23:12]};
  end

  // ******
  // Tasks
  // ******
  task automatic summarize();
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; waits for pready, the hang guard bounds it
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reset with new straps, then poll until they are latched
  task automatic restart(input logic [1:0] m, input logic c,
                         input logic p, input logic [2:0] a);
    int n;
    n = 0;
    de_r = 1'b0;
    @(posedge pclk);
    presetn <= 1'b0;
    mode <= m;
    color <= c;
    pol <= p;
    addr <= a;
    repeat (8) @(posedge pclk);
    // The link domain needs edges of its own inside reset
    repeat (2) @(posedge pix_clk);
    @(posedge pclk);
    presetn <= 1'b1;
    do begin
      apb(1'b0, plr_pkg::PLR_STATUS_OFS, 32'h00000000);
      n++;
    end while (rd[plr_pkg::PLR_ST_DONE_BIT] !== 1'b1 && n < 40);
    chk("status", {24'h000000, 1'b1, m, c, p, a}, rd);
    chk("slave_addr", {25'h0, plr_pkg::PLR_SADDR_HIGH, a},
        {25'h0, slave_addr});
  endtask

  // Start active video, let the lanes settle, compare what arrives
  task automatic look(input string nm, input logic [7:0] en,
                      input logic c2, input logic [26:0] ea,
                      input logic [26:0] eb);
    @(posedge pclk);
    de_r = 1'b1;
    repeat (10) @(posedge pix_clk);
    #1;
    chk("lane_enable", {24'h0, en}, {24'h0, lane_en});
    chk("second_lvds_clock_out_en", {31'h0, c2}, {31'h0, second_lvds_clock_out_en});
    chk("group_a", {5'h00, ea}, {5'h00, grp_a});
    chk("group_b", {5'h00, eb}, {5'h00, grp_b});
    chk("pair_bad", 32'h0, {31'h0, pair_bad});
    $display("Test %s done", nm);
  endtask

  // ******
  // Tests
  // ******
  initial begin
    sd = 1'b0;
    restart(2'h0, 1'b0, 1'b0, 3'h5);
    apb(1'b0, plr_pkg::PLR_SADDR_OFS, 32'h00000000);
    chk("saddr", {25'h0, plr_pkg::PLR_SADDR_HIGH, 3'h5}, rd);
    look("single", 8'h0F, 1'b0, {3'h4, px0}, 27'h0);
    sd = 1'b1;
    hs_r = 1'b1;
    restart(2'h1, 1'b1, 1'b0, 3'h2);
    look("split", 8'hFF, 1'b1, {3'h5, px0}, {3'h5, px1});
    sd = 1'b0;
    hs_r = 1'b0;
    vs_r = 1'b1;
    restart(2'h2, 1'b0, 1'b1, 3'h7);
    look("dual", 8'hFF, 1'b1, {3'h6, px0}, {3'h6, px1});
    // Registers: reset value, read-only status, unmapped, disable
    apb(1'b0, plr_pkg::PLR_CTRL_OFS, 32'h00000000);
    chk("ctrl", 32'h00000001, rd);
    apb(1'b1, plr_pkg::PLR_STATUS_OFS, 32'h00000000);
    apb(1'b0, plr_pkg::PLR_STATUS_OFS, 32'h00000000);
    chk("status_ro", 32'h000000CF, rd);
    apb(1'b0, 8'h0C, 32'h00000000);
    chk("unmapped_err", 32'h00000001, {31'h0, err});
    chk("unmapped_data", 32'h00000000, rd);
    apb(1'b1, plr_pkg::PLR_CTRL_OFS, 32'h00000000);
    apb(1'b0, plr_pkg::PLR_CTRL_OFS, 32'h00000000);
    chk("ctrl_off", 32'h00000000, rd);
    look("off", 8'hFF, 1'b1, 27'h0, 27'h0);
    summarize();
  end

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("ERROR timeout expected 0 seen %0d", cyc);
      summarize();
    end
  end
endmodule
